// ---- design/dsc_cfg.svh ----
// Purpose: constants shared by both ends of the daisy chain serial link
// Assumes: sys_clk at 125 MHz, link clock made by the controller end
// Notes:   offsets, field positions, reset values and timing counts
//
// What this block does
// - chip_select_n falling starts a new access
// - sample input on clock fall, update output on rise
// - controller ends every access by raising chip_select_n
// - accept frame only at 16 plus multiples of 8
// - bad count sets error flag, frame discarded
// - deselected: ignore clock and data, output released
// - select falling loads pending response into shifter
// - first output bit is error flag OR input
// - sleep: output stays released, no transfer
// - valid frame end: decode, write addressed register
// - controller keeps clock low at select edges
// - most significant bit first, both directions
// - controller frames carry control bits, then data
// - one shift register, sixteen clocks per device
// - chain: shift all devices' bits, then deselect
// - answer comes back in the following transfer
// - bad prefix or reserved register gives syntax frame
// - first response after reset is a special frame
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define DSC_FRAME_BITS   5'h10
`define DSC_STEP_WRAP    5'h18
`define DSC_CMD_MSB      15
`define DSC_CMD_LSB      14
`define DSC_ADDR_MSB     13
`define DSC_ADDR_LSB     8
`define DSC_DATA_MSB     7
`define DSC_NUM_REGS     6'h08
`define DSC_CMD_WRITE    2'h2
`define DSC_CMD_READ     2'h1

// ---------------------------------------------------------------
// special response frames and reset values
// ---------------------------------------------------------------
`define DSC_RESET_RESP   16'h4000
`define DSC_TER_RESP     16'h7F00
`define DSC_SYNTAX_RESP  16'h7E00
`define DSC_REG_RESET    8'h00

// ---------------------------------------------------------------
// timing, in ns, and derived cycle counts
// ---------------------------------------------------------------
`define DSC_CLK_NS       8
`define DSC_SCLK_NS      160
`define DSC_T_LEAD_NS    1000
`define DSC_T_LAG_NS     1000
`define DSC_T_TD_NS      1250
`define DSC_HALF_CYC     (`DSC_SCLK_NS / 2 / `DSC_CLK_NS)
`define DSC_LEAD_CYC     ((`DSC_T_LEAD_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_LAG_CYC      ((`DSC_T_LAG_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_TD_CYC       ((`DSC_T_TD_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)

`endif

// ---- design/dsc_pkg.sv ----
// Purpose: types shared by both ends of the serial link
// Assumes: constants come from dsc_cfg.svh
// Notes:   state codes are written out
package dsc_pkg;

	typedef logic [15:0] dsc_word_t;
	typedef logic [7:0]  dsc_byte_t;
	typedef logic [5:0]  dsc_addr_t;
	typedef logic [4:0]  dsc_cnt_t;
	typedef logic [7:0]  dsc_timer_t;

	typedef enum logic [1:0] {
		DSC_D_IDLE   = 2'b00,
		DSC_D_ACTIVE = 2'b01,
		DSC_D_SLEEP  = 2'b10
	} dsc_dstate_t;

	typedef enum logic [2:0] {
		DSC_M_IDLE = 3'b000,
		DSC_M_LEAD = 3'b001,
		DSC_M_HIGH = 3'b010,
		DSC_M_LOW  = 3'b011,
		DSC_M_LAG  = 3'b100,
		DSC_M_GAP  = 3'b101
	} dsc_mstate_t;

endpackage

// ---- design/dsc_if.sv ----
// Purpose: four-wire link between controller end and device end
// Assumes: controller drives select, clock and data in
// Notes:   serial_out_oe marks the cycles in which the device drives
`timescale 1ns/1ns
`default_nettype none
interface dsc_if;
	logic chip_select_n;
	logic serial_clk;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;

	modport device (
		input  chip_select_n,
		input  serial_clk,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);

	modport controller (
		output chip_select_n,
		output serial_clk,
		output serial_in,
		input  serial_out,
		input  serial_out_oe
	);
endinterface
`default_nettype wire

// ---- design/dsc_device.sv ----
// Purpose: device end of the daisy chain serial link
// Assumes: link pins are asynchronous to sys_clk and are synchronised
// Notes:   link clock must stay well below sys_clk / 6 for edge finding
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"
module dsc_device (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// serial link
	dsc_if.device                  link,
	// mode
	input  wire logic              sleep_mode,
	// register write side
	output logic                   wr_pulse,
	output dsc_pkg::dsc_addr_t     wr_addr,
	output dsc_pkg::dsc_byte_t     wr_data,
	// status
	output logic                   ter_flag,
	output logic                   frame_err,
	output logic                   syntax_err
);
	import dsc_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// modulo 8/16 step: counts to 16, then wraps 16..23
	function automatic dsc_cnt_t cnt_step(input dsc_cnt_t c);
		dsc_cnt_t n;
		n = c + 5'h01;
		if (n == `DSC_STEP_WRAP) begin
			n = `DSC_FRAME_BITS;
		end
		return n;
	endfunction

	function automatic logic cmd_legal(input dsc_word_t w);
		logic [1:0] c;
		c = w[`DSC_CMD_MSB:`DSC_CMD_LSB];
		return ((c == `DSC_CMD_WRITE) || (c == `DSC_CMD_READ)) &&
			(w[`DSC_ADDR_MSB:`DSC_ADDR_LSB] < `DSC_NUM_REGS);
	endfunction

	function automatic logic cmd_write(input dsc_word_t w);
		return w[`DSC_CMD_MSB:`DSC_CMD_LSB] == `DSC_CMD_WRITE;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// stage 0 is read by stage 1 only; edges compare stages 1 and 2
	logic [2:0]  cs_q;
	logic [2:0]  sclk_q;
	logic [1:0]  sdi_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cs_q   <= 3'h7;
			sclk_q <= 3'h0;
			sdi_q  <= 2'h0;
		end else begin
			cs_q   <= {cs_q[1:0], link.chip_select_n};
			sclk_q <= {sclk_q[1:0], link.serial_clk};
			sdi_q  <= {sdi_q[0], link.serial_in};
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic sclk_rise;
	logic sdi_s;

	assign cs_fall   = cs_q[2] & ~cs_q[1];
	assign cs_rise   = ~cs_q[2] & cs_q[1];
	assign sclk_fall = sclk_q[2] & ~sclk_q[1];
	assign sclk_rise = ~sclk_q[2] & sclk_q[1];
	assign sdi_s     = sdi_q[1];

	// ---------------------------------------------------------------
	// access state
	// ---------------------------------------------------------------
	dsc_dstate_t dstate;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dstate <= DSC_D_IDLE;
		end else begin
			case (dstate)
			DSC_D_IDLE: begin
				if (cs_fall) begin
					dstate <= sleep_mode ? DSC_D_SLEEP : DSC_D_ACTIVE;
				end
			end
			DSC_D_ACTIVE, DSC_D_SLEEP: begin
				if (cs_rise) begin
					dstate <= DSC_D_IDLE;
				end
			end
			default: begin
				dstate <= DSC_D_IDLE;
			end
			endcase
		end
	end

	logic active;
	logic starting;

	assign active   = (dstate == DSC_D_ACTIVE);
	assign starting = (dstate == DSC_D_IDLE) && cs_fall && !sleep_mode;

	// ---------------------------------------------------------------
	// shift register and pulse counter
	// ---------------------------------------------------------------
	dsc_word_t shift;
	dsc_word_t resp;
	dsc_cnt_t  cnt;
	logic      transmission_error_flag;
	logic      clk_bad;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shift <= 16'h0000;
			cnt   <= 5'h00;
		end else if (starting) begin
			shift <= {transmission_error_flag, resp[14:0]};
			cnt   <= 5'h00;
		end else if (active && sclk_fall) begin
			shift <= {shift[14:0], sdi_s};
			cnt   <= cnt_step(cnt);
		end
	end

	// clock seen high at either select edge spoils the access
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clk_bad <= 1'b0;
		end else if (starting) begin
			clk_bad <= sclk_q[1];
		end
	end

	// ---------------------------------------------------------------
	// serial output
	// ---------------------------------------------------------------
	// only the selected, awake device drives; a sleeper stays released
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			link.serial_out    <= 1'b0;
			link.serial_out_oe <= 1'b0;
		end else if (starting) begin
			link.serial_out    <= transmission_error_flag | sdi_s;
			link.serial_out_oe <= 1'b1;
		end else if (!active) begin
			link.serial_out    <= 1'b0;
			link.serial_out_oe <= 1'b0;
		end else if (cs_rise) begin
			link.serial_out    <= 1'b0;
			link.serial_out_oe <= 1'b0;
		end else if (sclk_rise) begin
			link.serial_out    <= shift[15];
		end
	end

	// ---------------------------------------------------------------
	// frame end check
	// ---------------------------------------------------------------
	logic frame_end;
	logic frame_ok;
	logic accept;
	logic reject;

	assign frame_end = active && cs_rise;
	assign frame_ok  = (cnt == `DSC_FRAME_BITS) && !clk_bad && !sclk_q[1];
	assign accept    = frame_end && frame_ok;
	assign reject    = frame_end && !frame_ok;

	// ---------------------------------------------------------------
	// transmission error flag
	// ---------------------------------------------------------------
	// a new fault wins over clearing the one already reported
	logic ter_told;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ter_told <= 1'b0;
		end else if (starting) begin
			ter_told <= transmission_error_flag;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			transmission_error_flag <= 1'b0;
		end else if (reject) begin
			transmission_error_flag <= 1'b1;
		end else if (accept && ter_told) begin
			transmission_error_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// register file and pending response
	// ---------------------------------------------------------------
	dsc_byte_t regs [`DSC_NUM_REGS];
	dsc_addr_t addr;
	dsc_byte_t data;
	logic      legal;

	assign addr  = shift[`DSC_ADDR_MSB:`DSC_ADDR_LSB];
	assign data  = shift[`DSC_DATA_MSB:0];
	assign legal = cmd_legal(shift);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `DSC_NUM_REGS; i++) begin
				regs[i] <= `DSC_REG_RESET;
			end
		end else if (accept && legal && cmd_write(shift)) begin
			regs[addr[2:0]] <= data;
		end
	end

	// the answer to this frame only leaves in the next access
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			resp <= `DSC_RESET_RESP;
		end else if (reject) begin
			resp <= `DSC_TER_RESP;
		end else if (accept && !legal) begin
			resp <= `DSC_SYNTAX_RESP;
		end else if (accept && cmd_write(shift)) begin
			resp <= {2'b00, addr, data};
		end else if (accept) begin
			resp <= {2'b00, addr, regs[addr[2:0]]};
		end
	end

	// ---------------------------------------------------------------
	// user side outputs
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_pulse   <= 1'b0;
			wr_addr    <= 6'h00;
			wr_data    <= 8'h00;
			frame_err  <= 1'b0;
			syntax_err <= 1'b0;
			ter_flag   <= 1'b0;
		end else begin
			wr_pulse   <= accept && legal && cmd_write(shift);
			if (accept) begin
				wr_addr <= addr;
				wr_data <= data;
			end
			frame_err  <= reject;
			syntax_err <= accept && !legal;
			ter_flag   <= transmission_error_flag;
		end
	end

endmodule
`default_nettype wire

// ---- design/dsc_controller.sv ----
// Purpose: controller end of the daisy chain serial link
// Assumes: one command word per access, padded with zero bytes
// Notes:   answers wait in a two-entry buffer; a full buffer stalls
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"
module dsc_controller (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// serial link
	dsc_if.controller              link,
	// command side
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire dsc_pkg::dsc_word_t cmd_word,
	input  wire logic [1:0]        extra_bytes,
	// answer side
	output logic                   rsp_valid,
	input  wire logic              rsp_ready,
	output dsc_pkg::dsc_word_t     rsp_word,
	// status
	output logic                   busy
);
	import dsc_pkg::*;

	// ---------------------------------------------------------------
	// answer line synchroniser
	// ---------------------------------------------------------------
	logic [1:0] sdo_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sdo_q <= 2'h0;
		end else begin
			sdo_q <= {sdo_q[0], link.serial_out};
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// data changes on the rising clock so the far end, sampling on
	// the fall through its own synchroniser, never sees it move
	dsc_mstate_t mstate;
	dsc_timer_t  timer;
	dsc_word_t   tx;
	dsc_word_t   rx;
	logic [5:0]  bits_left;
	logic [5:0]  bit_idx;
	logic        spare_v;
	logic        push;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mstate             <= DSC_M_IDLE;
			timer              <= 8'h00;
			tx                 <= 16'h0000;
			rx                 <= 16'h0000;
			bits_left          <= 6'h00;
			bit_idx            <= 6'h00;
			cmd_ready          <= 1'b0;
			push               <= 1'b0;
			link.chip_select_n <= 1'b1;
			link.serial_clk    <= 1'b0;
			link.serial_in     <= 1'b0;
		end else begin
			cmd_ready <= 1'b0;
			push      <= 1'b0;
			case (mstate)
			DSC_M_IDLE: begin
				if (cmd_valid && !spare_v && !cmd_ready) begin
					cmd_ready          <= 1'b1;
					link.chip_select_n <= 1'b0;
					link.serial_in     <= cmd_word[15];
					tx                 <= {cmd_word[14:0], 1'b0};
					bits_left <= 6'(`DSC_FRAME_BITS) +
						{1'b0, extra_bytes, 3'h0};
					bit_idx            <= 6'h00;
					timer              <= 8'(`DSC_LEAD_CYC);
					mstate             <= DSC_M_LEAD;
				end
			end
			DSC_M_LEAD: begin
				if (timer == 8'h00) begin
					link.serial_clk <= 1'b1;
					timer           <= 8'(`DSC_HALF_CYC - 1);
					mstate          <= DSC_M_HIGH;
				end else begin
					timer <= timer - 8'h01;
				end
			end
			DSC_M_HIGH: begin
				if (timer == 8'h00) begin
					link.serial_clk <= 1'b0;
					if (bit_idx < 6'(`DSC_FRAME_BITS)) begin
						rx <= {rx[14:0], sdo_q[1]};
					end
					bit_idx   <= bit_idx + 6'h01;
					bits_left <= bits_left - 6'h01;
					if (bits_left == 6'h01) begin
						timer  <= 8'(`DSC_LAG_CYC);
						mstate <= DSC_M_LAG;
					end else begin
						timer  <= 8'(`DSC_HALF_CYC - 1);
						mstate <= DSC_M_LOW;
					end
				end else begin
					timer <= timer - 8'h01;
				end
			end
			DSC_M_LOW: begin
				if (timer == 8'h00) begin
					link.serial_clk <= 1'b1;
					link.serial_in  <= tx[15];
					tx              <= {tx[14:0], 1'b0};
					timer           <= 8'(`DSC_HALF_CYC - 1);
					mstate          <= DSC_M_HIGH;
				end else begin
					timer <= timer - 8'h01;
				end
			end
			DSC_M_LAG: begin
				if (timer == 8'h00) begin
					link.chip_select_n <= 1'b1;
					link.serial_in     <= 1'b0;
					push               <= 1'b1;
					timer              <= 8'(`DSC_TD_CYC);
					mstate             <= DSC_M_GAP;
				end else begin
					timer <= timer - 8'h01;
				end
			end
			DSC_M_GAP: begin
				if (timer == 8'h00) begin
					mstate <= DSC_M_IDLE;
				end else begin
					timer <= timer - 8'h01;
				end
			end
			default: begin
				mstate <= DSC_M_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else begin
			busy <= (mstate != DSC_M_IDLE);
		end
	end

	// ---------------------------------------------------------------
	// two-entry answer buffer
	// ---------------------------------------------------------------
	// a new access starts only with the spare slot empty, so the one
	// answer in flight always has room
	dsc_word_t spare;
	logic      pop;

	assign pop = rsp_valid && rsp_ready;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_word  <= 16'h0000;
			spare_v   <= 1'b0;
			spare     <= 16'h0000;
		end else if (!rsp_valid || (pop && !spare_v)) begin
			rsp_valid <= push;
			if (push) begin
				rsp_word <= rx;
			end
		end else if (pop) begin
			rsp_word <= spare;
			spare_v  <= push;
			if (push) begin
				spare <= rx;
			end
		end else if (push) begin
			spare   <= rx;
			spare_v <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ---- verif/dsc_link_asserts.sv ----
// Purpose: concurrent checks on the link between the two ends
// Assumes: one sys_clk domain, resetn asynchronous active low
// Notes:   sleep is never used on the watched link
`timescale 1ns/1ns
`default_nettype none
module dsc_link_asserts (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// link wires
	input  wire logic chip_select_n,
	input  wire logic serial_clk,
	input  wire logic serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	logic       clk_q;
	logic [7:0] pulses;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ---------------------------------------------------------------
	// pulse count, cleared while deselected so frames stand alone
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clk_q  <= 1'b0;
			pulses <= 8'h00;
		end else begin
			clk_q <= serial_clk;
			if (chip_select_n)
				pulses <= 8'h00;
			else if (serial_clk && !clk_q)
				pulses <= pulses + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	oe_on_sel_a:
		assert property ($fell(chip_select_n) |-> ##[1:8] serial_out_oe)
		else $error("output not enabled after select");
	oe_idle_a:
		assert property (chip_select_n [*8] |-> !serial_out_oe)
		else $error("output driven while deselected");
	clk_edge_low_a:
		assert property ($changed(chip_select_n) |->
			!serial_clk && !$past(serial_clk))
		else $error("select moved with clock high");
	clk_idle_a:
		assert property (chip_select_n |-> !serial_clk)
		else $error("clock runs outside a frame");
	lead_low_a:
		assert property ($fell(chip_select_n) |-> !serial_clk [*8])
		else $error("clock rose too soon after select");
	din_hold_a:
		assert property (serial_clk && $past(serial_clk) |-> $stable(serial_in))
		else $error("data in moved while clock high");
	so_on_rise_a:
		assert property (!chip_select_n && serial_out_oe && $changed(serial_out)
			|-> serial_clk || $past(chip_select_n, 6))
		else $error("data out moved away from a clock rise");
	frame_len_a:
		assert property ($rose(chip_select_n) |->
			pulses >= 8'h10 && pulses[2:0] == 3'h0)
		else $error("frame length not 16 plus bytes");

	cover property ($rose(chip_select_n) && pulses == 8'h10);
	cover property ($rose(chip_select_n) && pulses == 8'h18);
	cover property ($rose(chip_select_n) && pulses == 8'h28);
endmodule
`default_nettype wire

// ---- verif/dsc_test.sv ----
// Purpose: self-checking bench for both link ends
// Assumes: second device is driven bit by bit to break framing on purpose
// Notes:   answers are predicted from a small register model
`timescale 1ns/1ns
`default_nettype none
`include "dsc_cfg.svh"
module dsc_test;
	import dsc_pkg::*;
	logic       sys_clk, resetn, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
	logic       busy, sleep2, wr_p1, wr_p2, ter1, ter2, fe_p1, fe_p2;
	logic       sy_p1, sy_p2, fb2;
	logic [1:0] extra;
	logic [23:0] g;
	dsc_word_t  cmd_word, rsp_word, pend;
	dsc_addr_t  wa1, wa2, la1, la2, ela;
	dsc_byte_t  wd1, wd2, ld1, ld2, eld;
	dsc_byte_t  regs [8];
	dsc_word_t  expq [$];
	int         fail_count, compares, wr1, syn1, wr2, fe2, ewr, esy, i;
	int         fe1, sy2;
	dsc_word_t  tw [10] = '{16'h8155, 16'h4100, 16'hC200, 16'h0200,
		16'h8A12, 16'h4700, 16'h1285, 16'h1234, 16'h87AA, 16'h4700};
	logic [1:0] te [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1,
		2'h3, 2'h0, 2'h0};

	dsc_if l1();
	dsc_if l2();
	// released device output shows as high impedance for the checks
	wire        so2;
	assign so2 = l2.serial_out_oe ? l2.serial_out : 1'bz;
	dsc_controller u_dsc_controller (.sys_clk(sys_clk), .resetn(resetn),
		.link(l1.controller), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_word(cmd_word), .extra_bytes(extra), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_word(rsp_word), .busy(busy));
	dsc_device u_dsc_device (.sys_clk(sys_clk), .resetn(resetn),
		.link(l1.device), .sleep_mode(1'b0), .wr_pulse(wr_p1),
		.wr_addr(wa1), .wr_data(wd1), .ter_flag(ter1), .frame_err(fe_p1),
		.syntax_err(sy_p1));
	dsc_device u_dsc_device_b (.sys_clk(sys_clk), .resetn(resetn),
		.link(l2.device), .sleep_mode(sleep2), .wr_pulse(wr_p2),
		.wr_addr(wa2), .wr_data(wd2), .ter_flag(ter2), .frame_err(fe_p2),
		.syntax_err(sy_p2));
	dsc_link_asserts u_dsc_link_asserts (.sys_clk(sys_clk), .resetn(resetn),
		.chip_select_n(l1.chip_select_n), .serial_clk(l1.serial_clk),
		.serial_in(l1.serial_in), .serial_out(l1.serial_out),
		.serial_out_oe(l1.serial_out_oe));

	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (wr_p1) begin
			wr1++;
			la1 = wa1;
			ld1 = wd1;
		end
		if (wr_p2) begin
			wr2++;
			la2 = wa2;
			ld2 = wd2;
		end
		if (sy_p1)
			syn1++;
		if (fe_p2)
			fe2++;
		if (fe_p1)
			fe1++;
		if (sy_p2)
			sy2++;
	end

	// ---------------------------------------------------------------
	// reporting and waits
	// ---------------------------------------------------------------
	task test_done;
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk_w(input dsc_word_t got, input dsc_word_t exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask
	task chk_b(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: bit %b, wanted %b", $time, got, exp);
		end
	endtask
	task tick(inout int n);
		@(posedge sys_clk);
		n++;
		if (n > 4000) begin
			fail_count++;
			$display("mismatch at %0t: wait ran out", $time);
			test_done();
		end
	endtask

	// ---------------------------------------------------------------
	// model and controller side traffic
	// ---------------------------------------------------------------
	task model(input dsc_word_t w, input logic [1:0] e);
		dsc_word_t d;
		d = (e == 2'h0) ? w : (e == 2'h1) ? {w[7:0], 8'h00} : 16'h0000;
		expq.push_back(pend);
		if (d[13:8] < 6'h08 && (d[15:14] == 2'h2 || d[15:14] == 2'h1)) begin
			if (d[15]) begin
				regs[d[10:8]] = d[7:0];
				ewr++;
				ela = d[13:8];
				eld = d[7:0];
			end
			pend = {2'h0, d[13:8], regs[d[10:8]]};
		end else begin
			pend = `DSC_SYNTAX_RESP;
			esy++;
		end
	endtask
	task issue(input dsc_word_t w, input logic [1:0] e);
		int n;
		n = 0;
		model(w, e);
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		extra     <= e;
		do tick(n); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		@(posedge sys_clk);
	endtask
	task pop;
		int n;
		n = 0;
		rsp_ready <= 1'b1;
		do tick(n); while (rsp_valid !== 1'b1);
		chk_w(rsp_word, expq.pop_front());
		rsp_ready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task idle;
		int n;
		n = 0;
		while (busy !== 1'b0) tick(n);
	endtask

	// frame on the second link, clock only inside the frame
	task send2(input logic [23:0] w, input int n, output logic [23:0] q);
		int k;
		q = 24'h00_0000;
		l2.serial_in     <= w[n-1];
		l2.chip_select_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		fb2 = so2;
		repeat (120) @(posedge sys_clk);
		for (k = n - 1; k >= 0; k--) begin
			l2.serial_in  <= w[k];
			l2.serial_clk <= 1'b1;
			repeat (10) @(posedge sys_clk);
			l2.serial_clk <= 1'b0;
			q[k] = so2;
			repeat (10) @(posedge sys_clk);
		end
		repeat (130) @(posedge sys_clk);
		l2.chip_select_n <= 1'b1;
		l2.serial_in     <= ~w[0];
		repeat (160) @(posedge sys_clk);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// one command per access, each answer checked one access later
	task scn_words;
		for (i = 0; i < 10; i++) begin
			issue(tw[i], te[i]);
			pop();
			idle();
		end
	endtask

	// answer buffer filled with the far side stalled, then drained
	task scn_stall;
		issue(16'h8366, 2'h0);
		idle();
		issue(16'h4300, 2'h0);
		idle();
		model(16'h4500, 2'h0);
		cmd_valid <= 1'b1;
		cmd_word  <= 16'h4500;
		repeat (200) @(posedge sys_clk);
		chk_b(busy, 1'b0);
		pop();
		i = 0;
		while (cmd_ready !== 1'b1) tick(i);
		cmd_valid <= 1'b0;
		pop();
		pop();
		idle();
		chk_b(rsp_valid, 1'b0);
		chk_w(16'(wr1), 16'(ewr));
		chk_w(16'(syn1), 16'(esy));
		chk_w({2'h0, la1, ld1}, {2'h0, ela, eld});
		chk_b(ter1, 1'b0);
		chk_w(16'(fe1), 16'h0000);
	endtask

	// second link: short frame, then error reported and cleared
	task scn_chain;
		send2(24'h00_0ABC, 12, g);
		chk_w(16'(fe2), 16'h0001);
		chk_b(ter2, 1'b1);
		send2(24'h43_8311, 24, g);
		chk_b(fb2, 1'b1);
		chk_w({1'b0, g[22:8]}, `DSC_TER_RESP & 16'h7FFF);
		chk_w({8'h00, g[7:0]}, 16'h0043);
		chk_b(ter2, 1'b0);
		chk_w(16'(wr2), 16'h0001);
		chk_w({2'h0, la2, ld2}, 16'h0311);
	endtask

	// second link: stray clocks while deselected, then a sleeping device
	task scn_quiet;
		repeat (3) begin
			l2.serial_clk <= 1'b1;
			repeat (10) @(posedge sys_clk);
			l2.serial_clk <= 1'b0;
			repeat (10) @(posedge sys_clk);
		end
		chk_b(so2, 1'bz);
		send2(24'h00_4100, 16, g);
		chk_w(g[15:0], 16'h0311);
		chk_w(16'(fe2), 16'h0001);
		chk_w(16'(sy2), 16'h0000);
		sleep2 <= 1'b1;
		@(posedge sys_clk);
		send2(24'h00_8422, 16, g);
		chk_b(fb2, 1'bz);
		chk_w(16'(wr2), 16'h0001);
		chk_b(so2, 1'bz);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		{cmd_valid, rsp_ready, sleep2, extra, cmd_word} = '0;
		{l2.chip_select_n, l2.serial_clk, l2.serial_in} = 3'h4;
		{fail_count, compares, wr1, syn1, wr2, fe2, ewr, esy} = '0;
		{fe1, sy2} = '0;
		foreach (regs[j]) regs[j] = `DSC_REG_RESET;
		pend = `DSC_RESET_RESP;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		scn_words();
		scn_stall();
		scn_chain();
		scn_quiet();
		test_done();
	end
endmodule
`default_nettype wire
